// [rtl/tdrc_top.sv]
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps

module tdrc_top #(
	parameter int WINDOW_TICKS = tdrc_pkg::CAL_WINDOW_TICKS
) (
	input  wire logic        pclk,            // Block clock, 100 MHz.
	input  wire logic        presetn,         // Battery-domain reset, active low.
	input  wire logic        psel,            // APB select.
	input  wire logic        penable,         // APB access phase.
	input  wire logic        pwrite,          // APB direction, high for write.
	input  wire logic [7:0]  paddr,           // APB byte address.
	input  wire logic [31:0] pwdata,          // APB write data.
	output logic      [31:0] prdata,          // APB read data.
	output logic             pready,          // APB ready.
	output logic             pslverr,         // APB error on unmapped address.
	input  wire logic        rtc_tick,        // Raw RTC clock tick, one-cycle pulse.
	input  wire logic        rtc_alarm_evt,   // RTC alarm event pulse.
	input  wire logic        rtc_second_evt,  // RTC second event pulse.
	input  wire logic        vdd_off,         // Main supply off indication, async.
	input  wire logic        tamper_pin_in,   // Tamper pin level, async.
	output logic             tamper_pin_out,  // Level driven onto the pin.
	output logic             tamper_pin_oe,   // High while the block drives the pin.
	output logic             pin_gpio_release,// High when the pin is free for GPIO.
	output logic             rtc_tick_cal,    // Calibrated RTC tick pulse.
	output logic             backup_clear,    // Pulse clearing all backup data registers.
	output logic             irq              // Level interrupt.
);

	// ----------------------------------------------------------------
	// Elaboration checks.
	// ----------------------------------------------------------------
	if (WINDOW_TICKS < 128 || WINDOW_TICKS > tdrc_pkg::CAL_WINDOW_TICKS) begin : g_window_chk
		$error("WINDOW_TICKS out of range");
	end

	localparam logic [19:0] WINDOW_LAST = 20'(WINDOW_TICKS - 1);

	// ----------------------------------------------------------------
	// Storage.
	// ----------------------------------------------------------------
	tdrc_pkg::tdrc_cal_reg_t  cal_reg;
	tdrc_pkg::tdrc_ctrl_reg_t ctrl_reg;
	tdrc_pkg::tdrc_pin_t      pin_drv;
	logic                     tamper_event_flag;
	logic                     tamper_interrupt_flag;
	logic                     tamper_irq_enable;
	logic [1:0]               irq_status;
	logic [1:0]               irq_enable;
	logic                     pin_meta;
	logic                     pin_sync;
	logic                     vdd_meta;
	logic                     vdd_sync;
	logic                     armed_active;
	logic                     tamper_hit;
	logic                     detect_on;
	logic                     active_level;
	logic [19:0]              window_cnt;
	logic [6:0]               drop_cnt;
	logic                     drop_tick;
	logic [4:0]               div_cnt;
	logic                     div_clk;
	logic                     sel_event;
	logic                     wr_en;
	logic                     rd_setup;
	logic                     addr_ok;
	logic [31:0]              next_prdata;

	// ----------------------------------------------------------------
	// APB decode.
	// ----------------------------------------------------------------

	// Zero wait state slave; writes land at the access-phase edge.
	assign pready   = 1'b1;
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;

	// Address decode for the mapped words.
	always_comb begin
		if (paddr == tdrc_pkg::OFS_CAL_PIN_OUT) begin
			addr_ok = 1'b1;
		end else if (paddr == tdrc_pkg::OFS_TAMPER_CTRL) begin
			addr_ok = 1'b1;
		end else if (paddr == tdrc_pkg::OFS_TAMPER_STS) begin
			addr_ok = 1'b1;
		end else if (paddr == tdrc_pkg::OFS_IRQ_STATUS) begin
			addr_ok = 1'b1;
		end else if (paddr == tdrc_pkg::OFS_IRQ_CLEAR) begin
			addr_ok = 1'b1;
		end else if (paddr == tdrc_pkg::OFS_IRQ_ENABLE) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Error answer only in the access phase of an unmapped access.
	assign pslverr = psel && penable && !addr_ok;

	// Read mux; write-only and reserved bits read as zero.
	always_comb begin
		next_prdata = 32'h0000_0000;
		if (paddr == tdrc_pkg::OFS_CAL_PIN_OUT) begin
			next_prdata[15:0] = {6'h00, cal_reg[9:0]};
		end else if (paddr == tdrc_pkg::OFS_TAMPER_CTRL) begin
			next_prdata[15:0] = {14'h0000, ctrl_reg[1:0]};
		end else if (paddr == tdrc_pkg::OFS_TAMPER_STS) begin
			next_prdata[tdrc_pkg::POS_TAMPER_INTERRUPT_FLAG]  = tamper_interrupt_flag;
			next_prdata[tdrc_pkg::POS_TAMPER_EVENT_FLAG]  = tamper_event_flag;
			next_prdata[tdrc_pkg::POS_TPIEN] = tamper_irq_enable;
		end else if (paddr == tdrc_pkg::OFS_IRQ_STATUS) begin
			next_prdata[1:0] = irq_status;
		end else if (paddr == tdrc_pkg::OFS_IRQ_ENABLE) begin
			next_prdata[1:0] = irq_enable;
		end else begin
			next_prdata = 32'h0000_0000;
		end
	end

	// Read data is captured in the setup phase and held for the access phase.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Synchronisers for the asynchronous inputs.
	// ----------------------------------------------------------------

	// Two flip-flops for the pin level and the supply indication.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			vdd_meta <= 1'b0;
			vdd_sync <= 1'b0;
		end else begin
			pin_meta <= tamper_pin_in;
			pin_sync <= pin_meta;
			vdd_meta <= vdd_off;
			vdd_sync <= vdd_meta;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------

	// Event output bits change only through presetn or a write; loss of main supply
	// clears the calibration output bit and wins over a write in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_reg <= tdrc_pkg::RST_CAL_PIN_OUT;
		end else begin
			if (wr_en && paddr == tdrc_pkg::OFS_CAL_PIN_OUT) begin
				cal_reg.event_output_select      <= pwdata[9];
				cal_reg.event_output_enable      <= pwdata[8];
				cal_reg.calibration_clock_output <= pwdata[7];
				cal_reg.clock_slowdown_value     <= pwdata[6:0];
			end
			if (vdd_sync) begin
				cal_reg.calibration_clock_output <= 1'b0;
			end
		end
	end

	// Tamper control; software keeps the polarity stable while enabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= tdrc_pkg::RST_TAMPER_CTRL;
		end else if (wr_en && paddr == tdrc_pkg::OFS_TAMPER_CTRL) begin
			ctrl_reg.tamper_polarity      <= pwdata[1];
			ctrl_reg.tamper_detect_enable <= pwdata[0];
		end
	end

	// Tamper interrupt enable and the extra interrupt mask.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tamper_irq_enable <= 1'b0;
			irq_enable        <= 2'h0;
		end else begin
			if (wr_en && paddr == tdrc_pkg::OFS_TAMPER_STS) begin
				tamper_irq_enable <= pwdata[tdrc_pkg::POS_TPIEN];
			end
			if (wr_en && paddr == tdrc_pkg::OFS_IRQ_ENABLE) begin
				irq_enable <= pwdata[1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Tamper detection.
	// ----------------------------------------------------------------

	// Detection runs only when enabled and the pin is not an output.
	assign detect_on    = ctrl_reg.tamper_detect_enable
	                      && !cal_reg.calibration_clock_output
	                      && !cal_reg.event_output_enable;
	assign active_level = pin_sync ^ ctrl_reg.tamper_polarity;

	// Edge of the armed-and-active condition, so a pin already active counts once.
	assign tamper_hit = detect_on && active_level && !armed_active;

	// Remembers that the current active period has been reported.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_active <= 1'b0;
		end else begin
			armed_active <= detect_on && active_level;
		end
	end

	// Backup data clear pulse, one cycle after detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			backup_clear <= 1'b0;
		end else begin
			backup_clear <= tamper_hit;
		end
	end

	// Event and interrupt flags; a new event wins over a clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tamper_event_flag     <= 1'b0;
			tamper_interrupt_flag <= 1'b0;
		end else begin
			if (tamper_hit) begin
				tamper_event_flag <= 1'b1;
			end else if (wr_en && paddr == tdrc_pkg::OFS_TAMPER_STS
			             && pwdata[tdrc_pkg::POS_TAMPER_EVENT_FLAG_CLR]) begin
				tamper_event_flag <= 1'b0;
			end
			if (tamper_hit && tamper_irq_enable) begin
				tamper_interrupt_flag <= 1'b1;
			end else if (wr_en && paddr == tdrc_pkg::OFS_TAMPER_STS
			             && pwdata[tdrc_pkg::POS_TAMPER_INTERRUPT_FLAG_CLR]) begin
				tamper_interrupt_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sticky interrupt status.
	// ----------------------------------------------------------------

	// Each bit is set by its event and cleared by writing one; set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 2'h0;
		end else begin
			for (int i = 0; i < tdrc_pkg::IRQ_BITS; i++) begin
				if ((i == tdrc_pkg::IRQ_BIT_TAMPER && tamper_hit)
				    || (i == tdrc_pkg::IRQ_BIT_CALLOST && vdd_sync
				        && cal_reg.calibration_clock_output)) begin
					irq_status[i] <= 1'b1;
				end else if (wr_en && paddr == tdrc_pkg::OFS_IRQ_CLEAR && pwdata[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
		end
	end

	// Interrupt level from the tamper interrupt flag or any enabled status bit.
	assign irq = tamper_interrupt_flag || (|(irq_status & irq_enable));

	// ----------------------------------------------------------------
	// RTC slow-down calibration.
	// ----------------------------------------------------------------

	// The first N raw ticks of each window are swallowed.
	assign drop_tick = rtc_tick && (drop_cnt < cal_reg.clock_slowdown_value);

	// Window position and count of ticks dropped in the window.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window_cnt <= 20'h00000;
			drop_cnt   <= 7'h00;
		end else if (rtc_tick) begin
			if (window_cnt == WINDOW_LAST) begin
				window_cnt <= 20'h00000;
				drop_cnt   <= 7'h00;
			end else begin
				window_cnt <= window_cnt + 20'h00001;
				if (drop_tick) begin
					drop_cnt <= drop_cnt + 7'h01;
				end
			end
		end
	end

	// Calibrated tick, registered.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtc_tick_cal <= 1'b0;
		end else begin
			rtc_tick_cal <= rtc_tick && !drop_tick;
		end
	end

	// Divider by 64 of the calibrated clock, toggling every 32 ticks.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 5'h00;
			div_clk <= 1'b0;
		end else if (rtc_tick_cal) begin
			div_cnt <= div_cnt + 5'h01;
			if (div_cnt == tdrc_pkg::DIV_HALF_LAST) begin
				div_clk <= !div_clk;
			end
		end
	end

	// ----------------------------------------------------------------
	// Shared pin output.
	// ----------------------------------------------------------------

	// Event choice by the select bit.
	assign sel_event = cal_reg.event_output_select ? rtc_second_evt : rtc_alarm_evt;

	// Pin drive; the calibration clock takes priority over the event.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_drv <= '0;
		end else if (cal_reg.calibration_clock_output) begin
			pin_drv <= '{out: div_clk, oe: 1'b1};
		end else if (cal_reg.event_output_enable) begin
			pin_drv <= '{out: sel_event, oe: 1'b1};
		end else begin
			pin_drv <= '0;
		end
	end

	assign tamper_pin_out = pin_drv.out;
	assign tamper_pin_oe  = pin_drv.oe;

	// Pin is free for general use only when detection and output are off.
	assign pin_gpio_release = !ctrl_reg.tamper_detect_enable && !pin_drv.oe;

endmodule

// [pkg/tdrc_pkg.sv]
package tdrc_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses on the APB bus).
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CAL_PIN_OUT = 8'h2c;
	localparam logic [7:0] OFS_TAMPER_CTRL = 8'h30;
	localparam logic [7:0] OFS_TAMPER_STS  = 8'h34;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'he0;
	localparam logic [7:0] OFS_IRQ_CLEAR   = 8'he4;
	localparam logic [7:0] OFS_IRQ_ENABLE  = 8'he8;

	// ----------------------------------------------------------------
	// Field positions.
	// ----------------------------------------------------------------
	localparam int POS_TAMPER_INTERRUPT_FLAG       = 9;
	localparam int POS_TAMPER_EVENT_FLAG       = 8;
	localparam int POS_TPIEN      = 2;
	localparam int POS_TAMPER_INTERRUPT_FLAG_CLR   = 1;
	localparam int POS_TAMPER_EVENT_FLAG_CLR   = 0;
	localparam int IRQ_BIT_TAMPER = 0;
	localparam int IRQ_BIT_CALLOST = 1;
	localparam int IRQ_BITS       = 2;

	// ----------------------------------------------------------------
	// Reset values and counts.
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_CAL_PIN_OUT  = 16'h0000;
	localparam logic [15:0] RST_TAMPER_CTRL  = 16'h0000;
	localparam int          CAL_WINDOW_LOG2  = 20;
	localparam int          CAL_WINDOW_TICKS = 1048576;
	localparam int          DIV_RATIO        = 64;
	localparam int          DIV_HALF         = DIV_RATIO / 2;
	localparam logic [4:0]  DIV_HALF_LAST    = 5'h1f;
	localparam logic [7:0]  TICK_PPM_MAX     = 8'h79;

	// Calibration and pin-output register layout.
	typedef struct packed {
		logic [5:0] reserved;
		logic       event_output_select;
		logic       event_output_enable;
		logic       calibration_clock_output;
		logic [6:0] clock_slowdown_value;
	} tdrc_cal_reg_t;

	// Tamper pin control register layout.
	typedef struct packed {
		logic [13:0] reserved;
		logic        tamper_polarity;
		logic        tamper_detect_enable;
	} tdrc_ctrl_reg_t;

	// Shared pin drive bundle.
	typedef struct packed {
		logic out;
		logic oe;
	} tdrc_pin_t;

endpackage

// [testbench/tdrc_chk.sv]
`timescale 1ns/1ps

// ------------------------------------------
// Port checker.
// ------------------------------------------
module tdrc_chk #(
	parameter int WINDOW_TICKS = tdrc_pkg::CAL_WINDOW_TICKS
) (
	input wire logic        pclk,             // Clock.
	input wire logic        presetn,          // Reset, active low.
	input wire logic        psel,             // APB select.
	input wire logic        penable,          // APB enable.
	input wire logic        pwrite,           // APB direction.
	input wire logic [7:0]  paddr,            // APB address.
	input wire logic [31:0] pwdata,           // APB write data.
	input wire logic [31:0] prdata,           // APB read data.
	input wire logic        pready,           // APB ready.
	input wire logic        pslverr,          // APB error.
	input wire logic        rtc_tick,         // Raw tick.
	input wire logic        rtc_alarm_evt,    // Alarm event.
	input wire logic        rtc_second_evt,   // Second event.
	input wire logic        vdd_off,          // Main supply off.
	input wire logic        tamper_pin_in,    // Pin level.
	input wire logic        tamper_pin_out,   // Pin drive level.
	input wire logic        tamper_pin_oe,    // Pin drive enable.
	input wire logic        pin_gpio_release, // Pin free flag.
	input wire logic        rtc_tick_cal,     // Calibrated tick.
	input wire logic        backup_clear,     // Backup clear pulse.
	input wire logic        irq               // Interrupt.
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] sh_cal;
	logic [1:0]  sh_ctl;
	logic [5:0]  vq;
	logic        wr, quiet, act, ev, idle, det_ok, evsel;

	// Decoded shadow state; quiet masks the supply-loss transient.
	assign wr = psel && penable && pwrite && pready;
	assign quiet = !vdd_off && (vq == 6'h00);
	assign ev = sh_cal[8] && !sh_cal[7];
	assign idle = (sh_cal[8:7] == 2'b00) && !sh_ctl[0];
	assign det_ok = sh_ctl[0] && (sh_cal[8:7] == 2'b00);
	assign act = det_ok && !sh_cal[7] && (tamper_pin_in ^ sh_ctl[1]);
	assign evsel = sh_cal[9] ? rtc_second_evt : rtc_alarm_evt;

	// Keeps a history of the supply-off input.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) vq <= 6'h00;
		else vq <= {vq[4:0], vdd_off};
	end

	// Mirrors the two control registers from bus writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_cal <= 16'h0000;
			sh_ctl <= 2'h0;
		end else begin
			if (wr && paddr == tdrc_pkg::OFS_CAL_PIN_OUT) sh_cal <= pwdata[15:0] & 16'h03ff;
			else if (vq[5]) sh_cal[7] <= 1'b0;
			if (wr && paddr == tdrc_pkg::OFS_TAMPER_CTRL) sh_ctl <= pwdata[1:0];
		end
	end

	ready_always_a: assert property (pready)
		else $error("ready low");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access");
	clear_pulse_a: assert property (backup_clear |=> !backup_clear)
		else $error("backup clear too long");
	clear_cause_a: assert property (quiet && backup_clear |-> $past(det_ok))
		else $error("backup clear without detection");
	tamper_hit_a: assert property (quiet && $rose(act) |-> ##[1:6] backup_clear)
		else $error("tamper missed");
	tick_cause_a: assert property (rtc_tick_cal |-> $past(rtc_tick))
		else $error("tick without raw tick");
	pin_free_a: assert property (quiet && idle && $past(idle) |-> pin_gpio_release)
		else $error("pin not released");
	event_out_a: assert property (quiet && ev && $past(ev) |->
		tamper_pin_oe && tamper_pin_out == $past(evsel))
		else $error("wrong event on pin");
	cal_drive_a: assert property (quiet && sh_cal[7] && $past(sh_cal[7]) |-> tamper_pin_oe)
		else $error("calibration clock not driven");

	cover property (backup_clear);
	cover property (quiet && ev && tamper_pin_out);
	cover property (quiet && sh_cal[7] && tamper_pin_oe);
endmodule

bind tdrc_top tdrc_chk #(.WINDOW_TICKS(WINDOW_TICKS)) tdrc_chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rtc_tick(rtc_tick), .rtc_alarm_evt(rtc_alarm_evt), .rtc_second_evt(rtc_second_evt),
	.vdd_off(vdd_off), .tamper_pin_in(tamper_pin_in), .tamper_pin_out(tamper_pin_out),
	.tamper_pin_oe(tamper_pin_oe), .pin_gpio_release(pin_gpio_release),
	.rtc_tick_cal(rtc_tick_cal), .backup_clear(backup_clear), .irq(irq)
);

// [testbench/tdrc_pin_model.sv]
`timescale 1ns/1ps

// External tamper switch that holds a level unless the block drives the pin.
module tdrc_pin_model (
	input  wire logic lvl,   // Switch level.
	input  wire logic p_out, // Block drive level.
	input  wire logic p_oe,  // Block drive enable.
	output logic      pin    // Resolved pin level.
);
	// The block's drive wins while its enable is high.
	assign pin = p_oe ? p_out : lvl;
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
	localparam int         WT  = 256;
	localparam logic [7:0] CAL = tdrc_pkg::OFS_CAL_PIN_OUT;
	localparam logic [7:0] CTL = tdrc_pkg::OFS_TAMPER_CTRL;
	localparam logic [7:0] STS = tdrc_pkg::OFS_TAMPER_STS;
	localparam logic [7:0] IST = tdrc_pkg::OFS_IRQ_STATUS;
	localparam logic [7:0] ICL = tdrc_pkg::OFS_IRQ_CLEAR;
	localparam logic [7:0] IEN = tdrc_pkg::OFS_IRQ_ENABLE;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        rtc_tick, rtc_alarm_evt, rtc_second_evt, vdd_off, tamper_pin_in;
	logic        tamper_pin_out, tamper_pin_oe, pin_gpio_release, rtc_tick_cal;
	logic        backup_clear, irq, lvl, tick_on, slv_err, b;
	int          err_total, tests_run, cyc, n;

	// Block under test with a short calibration window.
	tdrc_top #(.WINDOW_TICKS(WT)) tdrc_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rtc_tick(rtc_tick),
		.rtc_alarm_evt(rtc_alarm_evt), .rtc_second_evt(rtc_second_evt),
		.vdd_off(vdd_off), .tamper_pin_in(tamper_pin_in),
		.tamper_pin_out(tamper_pin_out), .tamper_pin_oe(tamper_pin_oe),
		.pin_gpio_release(pin_gpio_release), .rtc_tick_cal(rtc_tick_cal),
		.backup_clear(backup_clear), .irq(irq)
	);

	// Switch on the pin.
	tdrc_pin_model tdrc_pin_model_i (.lvl(lvl), .p_out(tamper_pin_out),
		.p_oe(tamper_pin_oe), .pin(tamper_pin_in));

	// Clock and raw ticks on every other cycle.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) rtc_tick <= tick_on & ~rtc_tick;

	// Cuts a hang short.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end

	// ------------------------------------------
	// Shared tasks.
	// ------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One APB transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		slv_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Counts backup-clear pulses over twelve cycles.
	task automatic cnt_bk();
		n = 0;
		repeat (12) begin
			@(posedge pclk);
			if (backup_clear === 1'b1) n++;
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------
	// Scenarios.
	// ------------------------------------------
	task automatic t_reset();
		check(pin_gpio_release, 1'b1, "pin free");
		apb(1'b0, CAL, 32'h0);
		check(rd, {16'h0, tdrc_pkg::RST_CAL_PIN_OUT}, "cal reset");
		apb(1'b1, CTL, 32'hfffc);
		apb(1'b0, CTL, 32'h0);
		check(rd, {16'h0, tdrc_pkg::RST_TAMPER_CTRL}, "ctrl reserved");
		apb(1'b0, 8'h3c, 32'h0);
		check(slv_err, 1'b1, "unmapped");
		$display("test reset done");
	endtask

	// Active-high tamper with the interrupt masked, then unmasked and cleared.
	task automatic t_high();
		apb(1'b1, CTL, 32'h1);
		@(negedge pclk);
		check(pin_gpio_release, 1'b0, "pin taken");
		lvl <= 1'b1;
		cnt_bk();
		check(n, 1, "high tamper");
		apb(1'b0, STS, 32'h0);
		check(rd, 32'h100, "event flag only");
		check(irq, 1'b0, "masked");
		apb(1'b0, IST, 32'h0);
		check(rd, 32'h1, "irq status");
		apb(1'b1, IEN, 32'h1);
		@(negedge pclk);
		check(irq, 1'b1, "unmasked");
		apb(1'b1, ICL, 32'h1);
		apb(1'b1, IEN, 32'h0);
		apb(1'b1, STS, 32'h1);
		@(negedge pclk);
		check(irq, 1'b0, "cleared");
		apb(1'b0, STS, 32'h0);
		check(rd, 32'h0, "flag cleared");
		apb(1'b1, CTL, 32'h0);
		lvl <= 1'b0;
		$display("test high done");
	endtask

	// Active-low tamper already present when detection is enabled.
	task automatic t_low();
		apb(1'b1, STS, 32'h4);
		apb(1'b1, CTL, 32'h2);
		apb(1'b1, CTL, 32'h3);
		cnt_bk();
		check(n, 1, "one event at enable");
		apb(1'b0, STS, 32'h0);
		check(rd, 32'h304, "both flags");
		check(irq, 1'b1, "tamper irq");
		apb(1'b1, STS, 32'h7);
		apb(1'b1, ICL, 32'h1);
		apb(1'b0, STS, 32'h0);
		check(rd, 32'h4, "flags cleared");
		check(irq, 1'b0, "irq cleared");
		apb(1'b1, CTL, 32'h0);
		apb(1'b1, STS, 32'h0);
		$display("test low done");
	endtask

	// Event output for both selections, with detection blocked meanwhile.
	task automatic t_evt();
		lvl <= 1'b1;
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, CAL, 32'h100 | (s << 9));
			for (int e = 0; e < 2; e++) begin
				@(posedge pclk);
				rtc_alarm_evt <= (e == 0);
				rtc_second_evt <= (e == 1);
				@(posedge pclk);
				rtc_alarm_evt <= 1'b0;
				rtc_second_evt <= 1'b0;
				@(negedge pclk);
				check(tamper_pin_out, s == e, "event on pin");
				check(tamper_pin_oe, 1'b1, "event drive");
			end
		end
		// The idle event output holds the pin low, which is active for low polarity.
		apb(1'b1, CTL, 32'h2);
		apb(1'b1, CTL, 32'h3);
		cnt_bk();
		check(n, 0, "blocked by output");
		apb(1'b1, CTL, 32'h0);
		lvl <= 1'b0;
		$display("test event done");
	endtask

	// Divided clock, supply loss and a second reset.
	task automatic t_cal();
		apb(1'b1, CAL, 32'h380);
		tick_on <= 1'b1;
		n = 0;
		@(negedge pclk);
		b = tamper_pin_out;
		while (tamper_pin_out === b && n < 300) begin
			@(negedge pclk);
			n++;
		end
		b = tamper_pin_out;
		n = 0;
		while (tamper_pin_out === b && n < 300) begin
			@(negedge pclk);
			n++;
		end
		check(n, tdrc_pkg::DIV_RATIO, "half period");
		tick_on <= 1'b0;
		vdd_off <= 1'b1;
		repeat (10) @(posedge pclk);
		vdd_off <= 1'b0;
		apb(1'b0, CAL, 32'h0);
		check(rd, 32'h300, "supply loss");
		apb(1'b0, IST, 32'h0);
		check(rd, 32'h2, "loss status");
		apb(1'b1, ICL, 32'h2);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CAL, 32'h0);
		check(rd, 32'h0, "battery reset");
		$display("test cal done");
	endtask

	// Dropped ticks over two windows for both ends of the range.
	task automatic t_slow();
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, CAL, i ? 32'h79 : 32'h0);
			tick_on <= 1'b1;
			repeat (2 * WT) @(posedge pclk);
			n = 0;
			repeat (4 * WT) begin
				@(negedge pclk);
				if (rtc_tick_cal === 1'b1) n++;
			end
			check(n, i ? 2 * (WT - 121) : 2 * WT, "calibrated ticks");
		end
		tick_on <= 1'b0;
		$display("test slow done");
	endtask

	// Main sequence.
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{rtc_tick, rtc_alarm_evt, rtc_second_evt, vdd_off, lvl, tick_on} = '0;
		{err_total, tests_run, cyc} = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_high();
		t_low();
		t_evt();
		t_cal();
		t_slow();
		results();
	end
endmodule
